/* File: psw_params.svh */
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH
// register byte offsets
`define PSW_OFF_CTRL     12'h000
`define PSW_OFF_RAMP     12'h004
`define PSW_OFF_LIMITS   12'h008
`define PSW_OFF_WARN     12'h00c
`define PSW_OFF_START    12'h010
`define PSW_OFF_SLEEP    12'h014
`define PSW_OFF_SDELAY   12'h018
`define PSW_OFF_BOOST    12'h01c
`define PSW_OFF_BTIME    12'h020
`define PSW_OFF_WAKE     12'h024
`define PSW_OFF_STATUS   12'h028
`define PSW_OFF_CMD      12'h02c
// reset values (0.1 Hz / 0.1 s / 0.01 s / 1 s units)
`define PSW_RST_RAMP     16'h0000
`define PSW_RST_LO_LIM   16'h0000
`define PSW_RST_HI_LIM   16'h0258
`define PSW_RST_WARN     16'h0064
`define PSW_RST_ACC      16'h01f4
`define PSW_RST_SREF     16'h0000
`define PSW_RST_SDELAY   16'h0014
// field limits
`define PSW_MAX_RAMP     16'h03e7
`define PSW_MAX_FREQ     16'h1766
`define PSW_MAX_ACC      16'h270f
`define PSW_MIN_ACC      16'h0001
`define PSW_MAX_SDELAY   16'h0e10
// timing: one tick per 0.1 s and per 1 s at 100 MHz
`define PSW_CLK_HZ       100000000
`define PSW_TICK_DS      (`PSW_CLK_HZ / 10)
`define PSW_TICK_S       (`PSW_CLK_HZ)
`endif

/* File: psw_pkg.sv */
package psw_pkg;
  // supervisor states
  typedef enum logic [2:0] {
    PSW_IDLE, PSW_RUN, PSW_BOOST, PSW_SLEEP, PSW_MANUAL
  } psw_state_e;
  // sleep detect modes
  typedef enum logic [2:0] {
    PSW_DET_NONE, PSW_DET_SWITCH, PSW_DET_SPEED, PSW_DET_POWER, PSW_DET_MULTI
  } psw_det_e;
  // process inputs grouped
  typedef struct packed {
    logic signed [15:0] feedback;
    logic signed [15:0] reference;
    logic signed [15:0] pid_out;
    logic        [15:0] out_freq;
    logic        [15:0] out_power;
  } psw_proc_s;
  // motor command outputs grouped
  typedef struct packed {
    logic signed [15:0] freq_cmd;
    logic               motor_run;
    logic               integ_en;
    logic               pid_active;
  } psw_cmd_s;
endpackage

/* File: psw_ctrl.sv */
`timescale 1ns/1ps
`include "psw_params.svh"
// Operation
// - ref ramp spans min-to-max, 0..99.9 s
// - inversion selects direct or reverse action
// - low output limit -599..599 Hz, default 0
// - high output limit 0..599 Hz, default 60
// - warning when error exceeds threshold
// - shunt input at one disables integration
// - startup accel time 0.01..99.99 s, default 5
// - start reference ignored below low speed
// - pid mode needs config, channel 1, auto
// - sleep after condition outlasts delay, no wake
// - sleep delay 0..3600 s, default 20
// - switch, speed or power sleep conditions
// - multiple mode ors configured conditions
// - feedback wake compares against process level
// - error wake compares against reference plus/minus
// - boost speed for boost time, then stop
// - zero boost time skips boost phase
// - run with wake condition starts pid
// - run without wake enters sleep, no boost
// - switch to auto while running keeps running
module psw_ctrl
  import psw_pkg::*;
#(
  parameter int TICK_DS = `PSW_TICK_DS, // cycles per 0.1 s
  parameter int TICK_S  = `PSW_TICK_S   // cycles per 1 s
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire psw_proc_s   proc_in,
  input  wire logic        run_order,
  input  wire logic        chan1_sel,
  input  wire logic        pid_auto,
  input  wire logic        sleep_switch,
  input  wire logic        shunt_in,
  output psw_cmd_s         cmd_out,
  output logic             err_warn,
  output logic             asleep
);

  // registers written by software
  logic               pid_cfg_r;    // pid configured
  logic               invert_r;     // reverse action
  logic               wake_err_r;   // wake on error
  logic               shunt_asg_r;  // shunt input assigned
  logic               shunt_bit_r;  // shunt command bit
  logic               sref_en_r;    // start reference enabled
  psw_det_e           det_r;        // sleep detect mode
  logic               m_sw_r;       // multi: switch used
  logic               m_spd_r;      // multi: speed used
  logic               m_pwr_r;      // multi: power used
  logic        [15:0] ramp_r;       // ramp time 0.1 s
  logic signed [15:0] lo_lim_r;     // low limit 0.1 Hz
  logic        [15:0] hi_lim_r;     // high limit 0.1 Hz
  logic        [15:0] warn_r;       // warning threshold
  logic        [15:0] acc_r;        // startup accel 0.01 s
  logic        [15:0] sref_r;       // start reference 0.1 Hz
  logic        [15:0] low_spd_r;    // low speed 0.1 Hz
  logic        [15:0] sl_spd_r;     // sleep speed
  logic        [15:0] sl_pwr_r;     // sleep power
  logic        [15:0] sdelay_r;     // sleep delay s
  logic        [15:0] bst_spd_r;    // boost speed
  logic        [15:0] btime_r;      // boost time s
  logic signed [15:0] wake_lvl_r;   // wake process level
  logic signed [15:0] wake_err_lvl_r; // wake error level

  // bus address phase capture
  logic        wr_pend_r;  // write data phase pending
  logic [11:0] addr_r;     // latched offset
  logic        rd_pend_r;  // read data phase pending

  // supervisor state
  psw_state_e         st_r;
  logic        [31:0] tick_cnt_r;   // prescaler
  logic        [15:0] sec_cnt_r;    // seconds counter
  logic signed [15:0] ramp_ref_r;   // ramped reference
  logic               prev_auto_r;  // pid mode last cycle
  logic               prev_run_r;   // run order last cycle

  // clamp helper used for several fields
  function automatic logic [15:0] lim(input logic [15:0] v,
                                       input logic [15:0] mx);
    lim = (v > mx) ? mx : v;
  endfunction

  // pid mode qualifier
  logic pid_mode;
  assign pid_mode = pid_cfg_r && chan1_sel && pid_auto;

  // wake conditions
  logic wake_fb, wake_er, wake_ok;
  logic signed [16:0] ref_lo, ref_hi;
  assign ref_lo = 17'(proc_in.reference) - 17'(wake_err_lvl_r);
  assign ref_hi = 17'(proc_in.reference) + 17'(wake_err_lvl_r);
  assign wake_fb = invert_r ? (proc_in.feedback > wake_lvl_r)
                            : (proc_in.feedback < wake_lvl_r);
  assign wake_er = invert_r ? (17'(proc_in.feedback) > ref_hi)
                            : (17'(proc_in.feedback) < ref_lo);
  assign wake_ok = wake_err_r ? wake_er : wake_fb;

  // sleep conditions per detect mode
  logic c_sw, c_spd, c_pwr, sleep_cond;
  assign c_sw  = sleep_switch;
  assign c_spd = proc_in.out_freq < sl_spd_r;
  assign c_pwr = proc_in.out_power < sl_pwr_r;
  always_comb
  begin
    unique case (det_r)
      PSW_DET_SWITCH: sleep_cond = c_sw;
      PSW_DET_SPEED:  sleep_cond = c_spd;
      PSW_DET_POWER:  sleep_cond = c_pwr;
      PSW_DET_MULTI:  sleep_cond = (m_sw_r && c_sw) ||
                                   (m_spd_r && c_spd) ||
                                   (m_pwr_r && c_pwr);
      default:        sleep_cond = 1'b0;
    endcase
  end

  // one-second tick from prescaler
  logic sec_tick;
  assign sec_tick = (tick_cnt_r == 32'(TICK_S - 1));

  // sleep condition that is allowed to advance the delay
  logic sleep_hold;
  assign sleep_hold = sleep_cond && !wake_ok &&
                      det_r != PSW_DET_NONE;

  // bus transfer qualifiers
  logic go;
  assign go = hsel && hready && htrans[1];

  // address phase capture, zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 12'h000;
    end
    else
    begin
      wr_pend_r <= go && hwrite;
      rd_pend_r <= go && !hwrite;
      if (go)
        addr_r <= haddr[11:0];
    end
  end

  // configuration writes with range limits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {pid_cfg_r, invert_r, wake_err_r, shunt_asg_r} <= 4'h0;
      {shunt_bit_r, sref_en_r, m_sw_r, m_spd_r, m_pwr_r} <= 5'h00;
      det_r     <= PSW_DET_NONE;
      ramp_r    <= `PSW_RST_RAMP;
      lo_lim_r  <= `PSW_RST_LO_LIM;
      hi_lim_r  <= `PSW_RST_HI_LIM;
      warn_r    <= `PSW_RST_WARN;
      acc_r     <= `PSW_RST_ACC;
      sref_r    <= `PSW_RST_SREF;
      low_spd_r <= 16'h0000;
      sl_spd_r  <= 16'h0000;
      sl_pwr_r  <= 16'h0000;
      sdelay_r  <= `PSW_RST_SDELAY;
      bst_spd_r <= 16'h0000;
      btime_r   <= 16'h0000;
      wake_lvl_r     <= 16'h0000;
      wake_err_lvl_r <= 16'h0000;
    end
    else if (wr_pend_r)
    begin
      unique case (addr_r)
        `PSW_OFF_CTRL:
        begin
          pid_cfg_r   <= hwdata[0];
          invert_r    <= hwdata[1];
          wake_err_r  <= hwdata[2];
          shunt_asg_r <= hwdata[3];
          sref_en_r   <= hwdata[4];
          m_sw_r      <= hwdata[8];
          m_spd_r     <= hwdata[9];
          m_pwr_r     <= hwdata[10];
          det_r <= (hwdata[7:5] > 3'h4) ? PSW_DET_NONE
                                        : psw_det_e'(hwdata[7:5]);
        end
        `PSW_OFF_RAMP:   ramp_r <= lim(hwdata[15:0], `PSW_MAX_RAMP);
        `PSW_OFF_LIMITS:
        begin
          // low limit within +-599.0 Hz
          if ($signed(hwdata[15:0]) > $signed(`PSW_MAX_FREQ))
            lo_lim_r <= `PSW_MAX_FREQ;
          else if ($signed(hwdata[15:0]) < -$signed(`PSW_MAX_FREQ))
            lo_lim_r <= -`PSW_MAX_FREQ;
          else
            lo_lim_r <= hwdata[15:0];
          hi_lim_r <= lim(hwdata[31:16], `PSW_MAX_FREQ);
        end
        `PSW_OFF_WARN:   warn_r <= hwdata[15:0];
        `PSW_OFF_START:
        begin
          acc_r  <= (hwdata[15:0] < `PSW_MIN_ACC) ? `PSW_MIN_ACC
                    : lim(hwdata[15:0], `PSW_MAX_ACC);
          sref_r <= lim(hwdata[31:16], `PSW_MAX_FREQ);
        end
        `PSW_OFF_SLEEP:
        begin
          sl_spd_r <= lim(hwdata[15:0], `PSW_MAX_FREQ);
          sl_pwr_r <= hwdata[31:16];
        end
        `PSW_OFF_SDELAY:
        begin
          sdelay_r  <= lim(hwdata[15:0], `PSW_MAX_SDELAY);
          low_spd_r <= lim(hwdata[31:16], `PSW_MAX_FREQ);
        end
        `PSW_OFF_BOOST:  bst_spd_r <= lim(hwdata[15:0], `PSW_MAX_FREQ);
        `PSW_OFF_BTIME:  btime_r <= lim(hwdata[15:0], `PSW_MAX_SDELAY);
        `PSW_OFF_WAKE:
        begin
          wake_lvl_r     <= hwdata[15:0];
          wake_err_lvl_r <= hwdata[31:16];
        end
        `PSW_OFF_CMD:    shunt_bit_r <= hwdata[0];
        default: ;
      endcase
    end
  end

  // read data, registered in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (go && !hwrite)
      begin
        unique case (haddr[11:0])
          `PSW_OFF_CTRL:   hrdata <= {21'h0, m_pwr_r, m_spd_r, m_sw_r,
                                      3'(det_r), sref_en_r, shunt_asg_r,
                                      wake_err_r, invert_r, pid_cfg_r};
          `PSW_OFF_RAMP:   hrdata <= {16'h0, ramp_r};
          `PSW_OFF_LIMITS: hrdata <= {hi_lim_r, lo_lim_r};
          `PSW_OFF_WARN:   hrdata <= {16'h0, warn_r};
          `PSW_OFF_START:  hrdata <= {sref_r, acc_r};
          `PSW_OFF_SLEEP:  hrdata <= {sl_pwr_r, sl_spd_r};
          `PSW_OFF_SDELAY: hrdata <= {low_spd_r, sdelay_r};
          `PSW_OFF_BOOST:  hrdata <= {16'h0, bst_spd_r};
          `PSW_OFF_BTIME:  hrdata <= {16'h0, btime_r};
          `PSW_OFF_WAKE:   hrdata <= {wake_err_lvl_r, wake_lvl_r};
          `PSW_OFF_STATUS: hrdata <= {16'h0, sec_cnt_r[7:0], 2'h0,
                                      pid_mode, err_warn, 1'b0,
                                      3'(st_r)};
          `PSW_OFF_CMD:    hrdata <= {31'h0, shunt_bit_r};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // prescaler for second ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tick_cnt_r <= 32'h0000_0000;
    // restart on a dropped hold so no partial second counts as delay
    else if (sec_tick || st_r == PSW_IDLE || st_r == PSW_MANUAL ||
             st_r == PSW_SLEEP || (st_r == PSW_RUN &&
             (!sleep_hold || sec_cnt_r >= sdelay_r)))
      tick_cnt_r <= 32'h0000_0000;
    else
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end

  // supervisor state machine with seconds counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r        <= PSW_IDLE;
      sec_cnt_r   <= 16'h0000;
      prev_auto_r <= 1'b0;
      prev_run_r  <= 1'b0;
    end
    else
    begin
      prev_auto_r <= pid_mode;
      prev_run_r  <= run_order;
      if (!run_order)
      begin
        st_r      <= PSW_IDLE;
        sec_cnt_r <= 16'h0000;
      end
      else
      begin
        unique case (st_r)
          PSW_IDLE:
          begin
            sec_cnt_r <= 16'h0000;
            if (!pid_mode)
              st_r <= PSW_MANUAL;
            else if (wake_ok || det_r == PSW_DET_NONE)
              st_r <= PSW_RUN;
            else
              st_r <= PSW_SLEEP;
          end
          PSW_MANUAL:
          begin
            sec_cnt_r <= 16'h0000;
            if (pid_mode)
              st_r <= PSW_RUN;
          end
          PSW_RUN:
          begin
            if (!pid_mode)
              st_r <= PSW_MANUAL;
            else if (!sleep_cond || wake_ok || det_r == PSW_DET_NONE)
              sec_cnt_r <= 16'h0000;
            else if (sec_cnt_r >= sdelay_r)
            begin
              sec_cnt_r <= 16'h0000;
              st_r <= (btime_r == 16'h0000) ? PSW_SLEEP
                                             : PSW_BOOST;
            end
            else if (sec_tick)
              sec_cnt_r <= sec_cnt_r + 16'h0001;
          end
          PSW_BOOST:
          begin
            if (sec_cnt_r >= btime_r)
            begin
              sec_cnt_r <= 16'h0000;
              st_r      <= PSW_SLEEP;
            end
            else if (sec_tick)
              sec_cnt_r <= sec_cnt_r + 16'h0001;
          end
          PSW_SLEEP:
          begin
            sec_cnt_r <= 16'h0000;
            if (!pid_mode)
              st_r <= PSW_MANUAL;
            else if (wake_ok)
              st_r <= PSW_RUN;
          end
        endcase
      end
    end
  end

  // reference ramp: step per 0.1 s tick is span over ramp time
  logic [31:0] ds_cnt_r;
  logic        ds_tick;
  logic signed [16:0] step;
  assign ds_tick = (ds_cnt_r == 32'(TICK_DS - 1));
  assign step = (ramp_r == 16'h0000) ? 17'sh0ffff
              : 17'(signed'({1'b0, hi_lim_r}) - 17'(lo_lim_r))
                / 17'(signed'({1'b0, ramp_r}));
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ds_cnt_r   <= 32'h0000_0000;
      ramp_ref_r <= 16'h0000;
    end
    else
    begin
      ds_cnt_r <= ds_tick ? 32'h0000_0000 : ds_cnt_r + 32'h0000_0001;
      if (ramp_r == 16'h0000)
        ramp_ref_r <= proc_in.reference;
      else if (ds_tick)
      begin
        if (17'(proc_in.reference) > 17'(ramp_ref_r) + step)
          ramp_ref_r <= 16'(17'(ramp_ref_r) + step);
        else if (17'(proc_in.reference) < 17'(ramp_ref_r) - step)
          ramp_ref_r <= 16'(17'(ramp_ref_r) - step);
        else
          ramp_ref_r <= proc_in.reference;
      end
    end
  end

  // frequency command and flags
  logic signed [15:0] run_freq, clamped;
  logic signed [16:0] pid_err;
  // start reference acts as a floor, compared as signed values
  assign run_freq = (sref_en_r && sref_r >= low_spd_r &&
                     17'(proc_in.pid_out) < $signed({1'b0, sref_r}))
                  ? sref_r : proc_in.pid_out;
  assign clamped = (run_freq < lo_lim_r) ? lo_lim_r
                 : (run_freq > $signed(hi_lim_r)) ? hi_lim_r
                 : run_freq;
  assign pid_err = 17'(ramp_ref_r) - 17'(proc_in.feedback);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_out  <= '0;
      err_warn <= 1'b0;
      asleep   <= 1'b0;
    end
    else
    begin
      cmd_out.motor_run  <= st_r == PSW_RUN || st_r == PSW_BOOST ||
                            st_r == PSW_MANUAL;
      cmd_out.pid_active <= st_r == PSW_RUN;
      // boost speed bypasses the controller output limits
      cmd_out.freq_cmd   <= (st_r == PSW_BOOST) ? bst_spd_r
                            : (st_r == PSW_RUN) ? clamped : 16'h0000;
      cmd_out.integ_en   <= !(shunt_asg_r &&
                              (shunt_in || shunt_bit_r));
      err_warn <= (pid_err < 0 ? -pid_err : pid_err) > 17'(warn_r);
      asleep   <= st_r == PSW_SLEEP;
    end
  end

  p_sleep_no_boost: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == PSW_RUN && run_order && pid_mode && sleep_cond && !wake_ok &&
    det_r != PSW_DET_NONE && sec_cnt_r >= sdelay_r && btime_r == 16'h0000
    |=> st_r == PSW_SLEEP)
    else $error("zero boost did not enter sleep");
  p_warn: assert property (@(posedge hclk) disable iff (!hresetn)
    (pid_err > $signed({1'b0, warn_r}) ||
     -pid_err > $signed({1'b0, warn_r})) |=> err_warn)
    else $error("warning missing");
  p_clamp_hi: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_out.pid_active && $stable(hi_lim_r) && $stable(lo_lim_r) &&
    lo_lim_r <= $signed(hi_lim_r)
    |-> cmd_out.freq_cmd <= $signed(hi_lim_r))
    else $error("output above high limit");
  p_shunt: assert property (@(posedge hclk) disable iff (!hresetn)
    shunt_asg_r && shunt_in |=> !cmd_out.integ_en)
    else $error("integration not disabled");
  p_run_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == PSW_IDLE && run_order && pid_mode && wake_ok |=> st_r == PSW_RUN)
    else $error("run with wake did not start");
  p_run_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == PSW_IDLE && run_order && pid_mode && !wake_ok &&
    det_r != PSW_DET_NONE |=> st_r == PSW_SLEEP ##1 !cmd_out.motor_run)
    else $error("run without wake did not sleep");
  p_auto_run: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == PSW_MANUAL && run_order && pid_mode |=> st_r == PSW_RUN)
    else $error("auto switch left run state");
  p_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_out.pid_active |-> $past(st_r) == PSW_RUN)
    else $error("pid active outside run");
  p_delay_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    st_r == PSW_RUN && run_order && pid_mode && !sleep_cond
    |=> sec_cnt_r == 16'h0000)
    else $error("delay timer kept counting");

endmodule // psw_ctrl

/* File: psw_proc_model.sv */
`timescale 1ns/1ps
// motor and sensor stand-in: speed follows the command one cycle late
module psw_proc_model
  import psw_pkg::*;
(
  input  wire psw_cmd_s           cmd,
  input  wire logic               hclk,
  input  wire logic signed [15:0] fb,
  input  wire logic signed [15:0] sp,
  input  wire logic signed [15:0] po,
  output psw_proc_s               proc
);
  logic [15:0] spd_r; // shaft speed, also used as power
  // a stopped motor reads zero speed and zero power
  always_ff @(posedge hclk)
  begin
    spd_r <= cmd.motor_run ? 16'(cmd.freq_cmd) : 16'h0000;
  end
  assign proc = '{fb, sp, po, spd_r, spd_r};
endmodule // psw_proc_model

/* File: test_pid_sleep_wake_control.sv */
`timescale 1ns/1ps
`include "psw_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_pid_sleep_wake_control
  import psw_pkg::*;
();
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, err_warn, asleep;
  logic run_order = 0, chan1_sel = 1, pid_auto = 1;
  logic sleep_switch = 0, shunt_in = 0;
  logic signed [15:0] fb = 16'sh0010, sp = 16'sh0100, po = 16'sh012c;
  psw_proc_s proc_in;
  psw_cmd_s cmd_out;
  int err_total = 0, samples_checked = 0;
  always #5 hclk = ~hclk;
  psw_ctrl #(.TICK_DS(5), .TICK_S(10)) dut (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .proc_in(proc_in), .run_order(run_order), .chan1_sel(chan1_sel),
    .pid_auto(pid_auto), .sleep_switch(sleep_switch),
    .shunt_in(shunt_in), .cmd_out(cmd_out), .err_warn(err_warn),
    .asleep(asleep));
  psw_proc_model far (.cmd(cmd_out), .hclk(hclk), .fb(fb), .sp(sp),
    .po(po), .proc(proc_in));
  // closing report
  task give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // wait for hready with a bound
  task rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      err_total++;
      give_verdict;
    end
  endtask
  // one single word transfer, read data left in rd
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  // bounded wait on the sleep flag
  task expect_sleep(input logic v);
    for (int n = 0; n < 100 && asleep !== v; n++)
      @(negedge hclk);
    `CHK("asleep", v, asleep)
  endtask
  // run, lose the wake condition, sleep, then wake again
  task sc(input logic [31:0] c, input logic signed [15:0] fw, fn);
    ahb(1'b1, `PSW_OFF_CTRL, c);
    @(posedge hclk);
    fb <= fw;
    run_order <= 1'b1;
    repeat (4) @(negedge hclk);
    `CHK("pid_active", 1'b1, cmd_out.pid_active)
    @(posedge hclk);
    fb <= fn;
    sleep_switch <= 1'b1;
    repeat (10) @(negedge hclk);
    if (c[7:5] == 3'h1)
      `CHK("early", 1'b0, asleep)
    expect_sleep(1'b1);
    `CHK("motor_run", 1'b0, cmd_out.motor_run)
    @(posedge hclk);
    fb <= fw;
    expect_sleep(1'b0);
    @(posedge hclk);
    run_order <= 1'b0;
    sleep_switch <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  initial
  begin
    #500000;
    err_total++;
    give_verdict;
  end
  initial
  begin
    logic [11:0] ra [5];
    logic [31:0] rv [5];
    int n;
    ra = '{`PSW_OFF_RAMP, `PSW_OFF_LIMITS, `PSW_OFF_WARN,
           `PSW_OFF_START, 12'h030};
    rv = '{{16'h0, `PSW_RST_RAMP}, {`PSW_RST_HI_LIM, `PSW_RST_LO_LIM},
           {16'h0, `PSW_RST_WARN}, {`PSW_RST_SREF, `PSW_RST_ACC}, 32'h0};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ra[i])
    begin
      ahb(1'b0, ra[i], 32'h0);
      `CHK("reset value", rv[i], rd)
    end
    ahb(1'b0, `PSW_OFF_SDELAY, 32'h0);
    `CHK("sleep delay", `PSW_RST_SDELAY, rd[15:0])
    ahb(1'b1, `PSW_OFF_RAMP, 32'hffff);
    ahb(1'b0, `PSW_OFF_RAMP, 32'h0);
    `CHK("ramp max", `PSW_MAX_RAMP, rd[15:0])
    ahb(1'b1, `PSW_OFF_RAMP, 32'h0);
    ahb(1'b1, `PSW_OFF_LIMITS, 32'h00c8_0064);
    ahb(1'b1, `PSW_OFF_SLEEP, 32'h0200_0200);
    ahb(1'b1, `PSW_OFF_SDELAY, 32'h0000_0004);
    ahb(1'b1, `PSW_OFF_WAKE, 32'h0020_0100);
    ahb(1'b1, `PSW_OFF_BOOST, 32'h0150);
    ahb(1'b1, `PSW_OFF_BTIME, 32'h0);
    $display("test registers done");
    ahb(1'b1, `PSW_OFF_CTRL, 32'h9);
    run_order <= 1'b1;
    fb <= 16'sh009c;
    shunt_in <= 1'b1;
    repeat (6) @(negedge hclk);
    `CHK("pid_active", 1'b1, cmd_out.pid_active)
    `CHK("clamp high", 16'sh00c8, cmd_out.freq_cmd)
    `CHK("warn at 100", 1'b0, err_warn)
    `CHK("integ_en", 1'b0, cmd_out.integ_en)
    @(posedge hclk);
    po <= -16'sh0032;
    fb <= 16'sh009b;
    shunt_in <= 1'b0;
    repeat (6) @(negedge hclk);
    `CHK("clamp low", 16'sh0064, cmd_out.freq_cmd)
    `CHK("warn at 101", 1'b1, err_warn)
    `CHK("integ_en", 1'b1, cmd_out.integ_en)
    ahb(1'b1, `PSW_OFF_START, 32'h0096_01f4);
    ahb(1'b1, `PSW_OFF_CTRL, 32'h19);
    repeat (3) @(negedge hclk);
    `CHK("start ref", 16'sh0096, cmd_out.freq_cmd)
    ahb(1'b1, `PSW_OFF_SDELAY, 32'h00c8_0004);
    repeat (3) @(negedge hclk);
    `CHK("start ref low", 16'sh0064, cmd_out.freq_cmd)
    ahb(1'b1, `PSW_OFF_SDELAY, 32'h0000_0004);
    chan1_sel <= 1'b0;
    repeat (4) @(negedge hclk);
    `CHK("pid_active", 1'b0, cmd_out.pid_active)
    ahb(1'b1, `PSW_OFF_CMD, 32'h1);
    chan1_sel <= 1'b1;
    repeat (6) @(negedge hclk);
    `CHK("auto switch", 1'b1, cmd_out.pid_active)
    `CHK("integ_en", 1'b0, cmd_out.integ_en)
    ahb(1'b1, `PSW_OFF_CMD, 32'h0);
    run_order <= 1'b0;
    $display("test pid path done");
    sc(32'h021, 16'sh0010, 16'sh0200);
    sc(32'h041, 16'sh0010, 16'sh0200);
    sc(32'h061, 16'sh0010, 16'sh0200);
    sc(32'h181, 16'sh0010, 16'sh0200);
    sc(32'h027, 16'sh0130, 16'sh0100);
    $display("test sleep and wake done");
    ahb(1'b1, `PSW_OFF_CTRL, 32'h021);
    ahb(1'b1, `PSW_OFF_BTIME, 32'h1);
    fb <= 16'sh0010;
    run_order <= 1'b1;
    repeat (4) @(posedge hclk);
    fb <= 16'sh0200;
    sleep_switch <= 1'b1;
    for (n = 0; n < 100 && cmd_out.freq_cmd !== 16'sh0150; n++)
      @(negedge hclk);
    `CHK("boost speed", 16'sh0150, cmd_out.freq_cmd)
    `CHK("boost run", 1'b1, cmd_out.motor_run)
    repeat (25) @(negedge hclk);
    `CHK("after boost", 1'b0, cmd_out.motor_run)
    @(posedge hclk);
    run_order <= 1'b0;
    repeat (4) @(posedge hclk);
    run_order <= 1'b1;
    repeat (3) @(negedge hclk);
    `CHK("no boost", 1'b0, cmd_out.motor_run)
    expect_sleep(1'b1);
    $display("test boost and start done");
    give_verdict;
  end
endmodule // test_pid_sleep_wake_control
